/* tmrc_pkg.sv */
// Contract
// - 16-bit counter, byte writes replace live count
// - Run off stops; gate enable gates counting
// - Source select picks clock source
// - Instruction clock counts once per cycle
// - System clock counts four per cycle
// - External source counts on rising edge
// - Falling edge required after enable, write, disable
// - Prescaler divides by 1, 2, 4, 8
// - Prescaler hidden; cleared on count writes
// - Crystal enable starts oscillator, runs in sleep
// - Sync disable lets external sources count in sleep; synchronizer still used
// - Async external keeps counting in sleep, wakes
// - Mode switch may lose or add one
// - Rollover to zero sets sticky overflow flag
// - Gate counts when level equals polarity
// - Async byte reads always valid
package tmrc_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [11:0] TMRC_OFS_CTRL = 12'h000;
	localparam logic [11:0] TMRC_OFS_GATE = 12'h004;
	localparam logic [11:0] TMRC_OFS_CNTL = 12'h008;
	localparam logic [11:0] TMRC_OFS_CNTH = 12'h00C;
	localparam logic [11:0] TMRC_OFS_STAT = 12'h010;
	localparam logic [11:0] TMRC_OFS_MASK = 12'h014;

	// ==========================================================
	// Control and gate register fields
	localparam int TMRC_CTRL_RUN = 0;
	localparam int TMRC_CTRL_SYNCDIS = 2;
	localparam int TMRC_CTRL_OSCEN = 3;
	localparam int TMRC_CTRL_PS = 4;
	localparam int TMRC_CTRL_SRC = 6;
	localparam int TMRC_GATE_EN = 7;
	localparam int TMRC_GATE_POL = 6;

	// ==========================================================
	// Source select codes
	localparam logic [1:0] TMRC_SRC_INSTR = 2'h0;
	localparam logic [1:0] TMRC_SRC_SYS = 2'h1;
	localparam logic [1:0] TMRC_SRC_EXT = 2'h2;
	localparam logic [1:0] TMRC_SRC_CAPS = 2'h3;

	// ==========================================================
	// Reset values and timing
	localparam logic [7:0] TMRC_CTRL_RST = 8'h00;
	localparam logic [15:0] TMRC_CNT_RST = 16'h0000;
	localparam int TMRC_INSTR_DIV = 4;
	localparam logic [1:0] TMRC_INSTR_LAST = 2'(TMRC_INSTR_DIV - 1);

	// Arm state: external rising edges count only after a falling edge
	typedef enum logic [1:0] {ARM_WAIT_LOW, ARM_READY} tmrc_arm_t;

endpackage : tmrc_pkg

/* tmrc_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Tick from the source stage to the counter core
interface tmrc_if;
	logic tick;
	logic armed;
	modport src (output tick, output armed);
	modport core (input tick, input armed);
endinterface : tmrc_if
`default_nettype wire

/* tmrc_source.sv */
`timescale 1ns/1ps
`default_nettype none
// Source selection, synchronizer, arm logic and prescaler
module tmrc_source
	import tmrc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Configuration
	input wire logic [1:0] srcSel,
	input wire logic oscEn,
	input wire logic syncDis,
	input wire logic [1:0] prescale,
	input wire logic countEn,
	input wire logic countWrite,
	// Raw inputs
	input wire logic extPin,
	input wire logic xtalIn,
	input wire logic capsOsc,
	// To counter core
	tmrc_if.src tk
);
	typedef struct packed {
		logic [2:0] sync;
		logic [1:0] phase;
		logic [2:0] pre;
		logic runOld;
		tmrc_arm_t arm;
		logic tick;
	} tmrc_src_t;

	tmrc_src_t s_q, s_d;
	logic extSel;
	logic extRaw;
	logic extRise;
	logic extFall;
	logic rawTick;
	logic [2:0] preMask;

	// Selected external level; caps oscillator when selected, else crystal when the oscillator is on
	assign extSel = srcSel[1];
	assign extRaw = (srcSel == TMRC_SRC_CAPS) ? capsOsc :
		(oscEn ? xtalIn : extPin);
	// Edges seen between synchronizer stages 2 and 3
	assign extRise = syncDis ? (s_q.sync[1] & ~s_q.sync[2]) :
		(s_q.sync[1] & ~s_q.sync[2]);
	assign extFall = ~s_q.sync[1] & s_q.sync[2];
	assign preMask = 3'((4'h1 << prescale) - 4'h1);

	// Raw clock tick ahead of the prescaler
	always_comb
	begin
		case (srcSel)
			TMRC_SRC_SYS: rawTick = 1'b1;
			TMRC_SRC_INSTR: rawTick = (s_q.phase == TMRC_INSTR_LAST);
			default: rawTick = extRise && s_q.arm == ARM_READY;
		endcase
	end

	// Next state
	always_comb
	begin
		s_d = s_q;
		s_d.sync = {s_q.sync[1:0], extRaw};
		s_d.phase = s_q.phase + 2'h1;
		s_d.runOld = countEn;
		s_d.tick = 1'b0;
		// Arm needs a falling edge after enable, write or disable
		if (countWrite || !countEn || (countEn && !s_q.runOld))
			s_d.arm = ARM_WAIT_LOW;
		else if (extFall)
			s_d.arm = ARM_READY;
		if (countWrite)
			s_d.pre = 3'h0;
		else if (countEn && rawTick)
		begin
			if ((s_q.pre & preMask) == preMask)
			begin
				s_d.pre = 3'h0;
				s_d.tick = 1'b1;
			end
			else
				s_d.pre = s_q.pre + 3'h1;
		end
		if (!rstn)
		begin
			s_d = '0;
			s_d.arm = ARM_WAIT_LOW;
		end
	end

	// State register
	always_ff @(posedge clock)
	begin
		s_q <= s_d;
	end

	assign tk.tick = s_q.tick;
	assign tk.armed = (s_q.arm == ARM_READY) || !extSel;
endmodule : tmrc_source
`default_nettype wire

/* tmrc_top.sv */
`timescale 1ns/1ps
`default_nettype none
// 16-bit timer/counter with APB registers
module tmrc_top
	import tmrc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins
	input wire logic externalClockPin,
	input wire logic crystalInPin,
	output logic crystalOutPin,
	input wire logic capsOsc,
	input wire logic gateSignal,
	input wire logic sleepMode,
	// Interrupt
	output logic irq
);
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] gate;
		logic [15:0] count;
		logic ovf;
		logic mask;
		logic [2:0] gsync;
		logic [31:0] rdata;
	} tmrc_top_t;

	tmrc_top_t r_q, r_d;
	tmrc_if tk();
	logic wrEn;
	logic rdEn;
	logic runBit;
	logic gateOk;
	logic countEn;
	logic countWrite;
	logic inc;

	// ==========================================================
	// Bus decode
	assign wrEn = psel && penable && pwrite;
	assign rdEn = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign countWrite = wrEn &&
		(paddr == TMRC_OFS_CNTL || paddr == TMRC_OFS_CNTH);

	// ==========================================================
	// Enable and gate
	assign runBit = r_q.ctrl[TMRC_CTRL_RUN];
	// Gate level after three-stage sync, compared with polarity
	assign gateOk = !r_q.gate[TMRC_GATE_EN] ||
		(r_q.gsync[2] == r_q.gate[TMRC_GATE_POL]);
	assign countEn = runBit;
	// Sleep halts synchronous and internal sources only
	assign inc = tk.tick && tk.armed && gateOk && !countWrite &&
		(!sleepMode || (r_q.ctrl[TMRC_CTRL_SRC+1] &&
		r_q.ctrl[TMRC_CTRL_SYNCDIS]));

	// Crystal amplifier output driven while the oscillator is on
	assign crystalOutPin = r_q.ctrl[TMRC_CTRL_OSCEN] & ~crystalInPin;

	// Source stage
	tmrc_source tmrc_source_inst (
		.clock(clock),
		.rstn(rstn),
		.srcSel(r_q.ctrl[TMRC_CTRL_SRC +: 2]),
		.oscEn(r_q.ctrl[TMRC_CTRL_OSCEN]),
		.syncDis(r_q.ctrl[TMRC_CTRL_SYNCDIS]),
		.prescale(r_q.ctrl[TMRC_CTRL_PS +: 2]),
		.countEn(countEn),
		.countWrite(countWrite),
		.extPin(externalClockPin),
		.xtalIn(crystalInPin),
		.capsOsc(capsOsc),
		.tk(tk.src)
	);

	// ==========================================================
	// Next state
	always_comb
	begin
		r_d = r_q;
		r_d.gsync = {r_q.gsync[1:0], gateSignal};
		// Counter increment and rollover
		if (inc)
		begin
			r_d.count = r_q.count + 16'h0001;
			if (r_q.count == 16'hFFFF)
				r_d.ovf = 1'b1;
		end
		if (wrEn)
		begin
			case (paddr)
				TMRC_OFS_CTRL: r_d.ctrl = pwdata[7:0];
				TMRC_OFS_GATE: r_d.gate = pwdata[7:0];
				TMRC_OFS_CNTL: r_d.count[7:0] = pwdata[7:0];
				TMRC_OFS_CNTH: r_d.count[15:8] = pwdata[7:0];
				TMRC_OFS_STAT:
					if (pwdata[0] && !(inc && r_q.count == 16'hFFFF))
						r_d.ovf = 1'b0;
				TMRC_OFS_MASK: r_d.mask = pwdata[0];
				default: ;
			endcase
		end
		// Read data from registered count: bytes always whole
		r_d.rdata = 32'h0000_0000;
		if (psel && !penable && !pwrite)
		begin
			case (paddr)
				TMRC_OFS_CTRL: r_d.rdata = {24'h00_0000, r_q.ctrl};
				TMRC_OFS_GATE: r_d.rdata = {24'h00_0000, r_q.gate};
				TMRC_OFS_CNTL: r_d.rdata = {24'h00_0000, r_q.count[7:0]};
				TMRC_OFS_CNTH: r_d.rdata = {24'h00_0000, r_q.count[15:8]};
				TMRC_OFS_STAT: r_d.rdata = {31'h0000_0000, r_q.ovf};
				TMRC_OFS_MASK: r_d.rdata = {31'h0000_0000, r_q.mask};
				default: r_d.rdata = 32'h0000_0000;
			endcase
		end
		else if (!rdEn)
			r_d.rdata = 32'h0000_0000;
		else
			r_d.rdata = r_q.rdata;
		if (!rstn)
		begin
			r_d = '0;
			r_d.ctrl = TMRC_CTRL_RST;
			r_d.count = TMRC_CNT_RST;
		end
	end

	// State register
	always_ff @(posedge clock)
	begin
		r_q <= r_d;
	end

	assign prdata = r_q.rdata;
	assign irq = r_q.ovf & r_q.mask;
endmodule : tmrc_top
`default_nettype wire

/* tmrc_ext_src.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Far-side clock source
module tmrc_ext_src
(
	// Clock and enable
	input wire logic clock,
	input wire logic en,
	// Square wave, period eight clocks
	output logic pin
);
	logic [2:0] cnt_q;
	// Stands low while disabled
	always_ff @(posedge clock)
		cnt_q <= en ? cnt_q + 3'h1 : 3'h0;
	assign pin = cnt_q[2];
endmodule : tmrc_ext_src
`default_nettype wire

/* tmrc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module tmrc_monitor
	import tmrc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins
	input wire logic crystalInPin,
	input wire logic crystalOutPin,
	input wire logic irq
);
	logic mask_q;
	logic osc_q;
	// Mask and oscillator bits as last written
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			mask_q <= 1'b0;
			osc_q <= 1'b0;
		end
		else if (psel && penable && pwrite)
		begin
			if (paddr == TMRC_OFS_MASK)
				mask_q <= pwdata[0];
			if (paddr == TMRC_OFS_CTRL)
				osc_q <= pwdata[TMRC_CTRL_OSCEN];
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	chk_ready_high:
	assert property (pready) else $error("pready low");
	chk_error_low:
	assert property (!pslverr) else $error("pslverr high");
	chk_data_idle:
	assert property (!penable && !$past(psel && penable && !pwrite) |->
		prdata == 32'h0) else $error("stale data");
	chk_byte_width:
	assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper bits set");
	chk_unmapped_zero:
	assert property (psel && penable && paddr > TMRC_OFS_MASK |-> !prdata)
		else $error("unmapped data");
	chk_xtal_amp:
	assert property (crystalOutPin == (osc_q && !crystalInPin))
		else $error("amplifier wrong");
	chk_irq_mask:
	assert property (irq |-> mask_q || $past(mask_q))
		else $error("irq while masked");
	chk_reset_quiet:
	assert property (disable iff (1'b0) !rstn [*2] |-> !irq && !prdata)
		else $error("reset not clean");
endmodule : tmrc_monitor
bind tmrc_top tmrc_monitor tmrc_monitor_inst (.clock, .rstn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.crystalInPin, .crystalOutPin, .irq);
`default_nettype wire

/* tmrc_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Self-checking bench
module tmrc_bench
	import tmrc_pkg::*;
;
	logic clock, rstn, psel, penable, pwrite, pready, pslverr;
	logic crystalOutPin, gateSignal, irq, extPin, extEn, sleepMode;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	int checks, nMismatch;
	tmrc_top tmrc_top_inst (.clock, .rstn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr,
		.externalClockPin(extPin), .crystalInPin(extPin), .crystalOutPin,
		.capsOsc(extPin), .gateSignal, .sleepMode, .irq);
	tmrc_ext_src tmrc_ext_src_inst (.clock, .en(extEn), .pin(extPin));
	// Clock, 100 ns period
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	task automatic results;
		$display("checks %0d mismatches %0d", checks, nMismatch);
		if (nMismatch == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	task automatic tmo;
		nMismatch++;
		results();
	endtask : tmo
	task automatic chk(input logic [31:0] g, input logic [31:0] lo, hi);
		checks++;
		if ((g >= lo && g <= hi) !== 1'b1)
		begin
			nMismatch++;
			$display("MISMATCH t=%0t got %h exp %h..%h", $time, g, lo, hi);
		end
	endtask : chk
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		for (int n = 0; pready !== 1'b1; n++)
		begin
			if (n > 50)
				tmo();
			@(posedge clock);
		end
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask : wr
	task automatic rdchk(input logic [11:0] a, input logic [31:0] lo, hi);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		chk(r, lo, hi);
	endtask : rdchk
	task automatic chkIrq(input logic e);
		@(negedge clock);
		chk({31'h0, irq}, {31'h0, e}, {31'h0, e});
		@(posedge clock);
	endtask : chkIrq
	// Count from zero for 160 edges, then read both bytes
	task automatic run(input logic [7:0] c, input logic [31:0] lo, hi);
		logic [31:0] l, h;
		wr(TMRC_OFS_CNTL, 32'h0);
		wr(TMRC_OFS_CNTH, 32'h0);
		if (c[3])
		begin
			wr(TMRC_OFS_CTRL, 32'h8);
			repeat (20) @(posedge clock);
		end
		wr(TMRC_OFS_CTRL, {24'h0, c});
		repeat (157) @(posedge clock);
		wr(TMRC_OFS_CTRL, 32'h0);
		apb(1'b0, TMRC_OFS_CNTL, 32'h0, l);
		apb(1'b0, TMRC_OFS_CNTH, 32'h0, h);
		chk({16'h0, h[7:0], l[7:0]}, lo, hi);
	endtask : run
	task automatic t_regs;
		rdchk(TMRC_OFS_CTRL, 0, 0);
		rdchk(TMRC_OFS_STAT, 0, 0);
		rdchk(12'h020, 0, 0);
		wr(TMRC_OFS_CNTL, 32'h34);
		wr(TMRC_OFS_CNTH, 32'h12);
		repeat (20) @(posedge clock);
		rdchk(TMRC_OFS_CNTL, 32'h34, 32'h34);
		rdchk(TMRC_OFS_CNTH, 32'h12, 32'h12);
		$display("register test done");
	endtask : t_regs
	task automatic t_src;
		logic [7:0] codes [3] = '{8'h81, 8'h89, 8'hC1};
		run(8'h01, 38, 41);
		for (int p = 0; p < 4; p++)
			run({2'h1, 2'(p), 4'h1}, (160 >> p) - 2, (160 >> p) + 1);
		extEn <= 1'b1;
		foreach (codes[i])
			run(codes[i], 18, 21);
		extEn <= 1'b0;
		for (int g = 0; g < 2; g++)
		begin
			wr(TMRC_OFS_GATE, {24'h0, 1'b1, 1'(g), 6'h0});
			gateSignal <= ~1'(g);
			run(8'h41, 0, 0);
			gateSignal <= 1'(g);
			run(8'h41, 158, 161);
		end
		wr(TMRC_OFS_GATE, 32'h0);
		// Asleep: system clock halts, async external keeps going
		sleepMode <= 1'b1;
		run(8'h41, 0, 0);
		extEn <= 1'b1;
		run(8'h85, 18, 21);
		extEn <= 1'b0;
		sleepMode <= 1'b0;
		$display("source test done");
	endtask : t_src
	task automatic t_ovf;
		for (int m = 1; m >= 0; m--)
		begin
			wr(TMRC_OFS_MASK, 32'(m));
			wr(TMRC_OFS_CNTL, 32'hFF);
			wr(TMRC_OFS_CNTH, 32'hFF);
			wr(TMRC_OFS_CTRL, 32'h41);
			repeat (12) @(posedge clock);
			chkIrq(1'(m));
			wr(TMRC_OFS_CTRL, 32'h0);
			rdchk(TMRC_OFS_STAT, 1, 1);
			rdchk(TMRC_OFS_CNTH, 0, 0);
			wr(TMRC_OFS_STAT, 32'h1);
			rdchk(TMRC_OFS_STAT, 0, 0);
			chkIrq(1'b0);
		end
		$display("overflow test done");
	endtask : t_ovf
	// Reset while counting with the flag set
	task automatic t_rst;
		wr(TMRC_OFS_MASK, 32'h1);
		wr(TMRC_OFS_CNTL, 32'hFF);
		wr(TMRC_OFS_CNTH, 32'hFF);
		wr(TMRC_OFS_CTRL, 32'h41);
		repeat (8) @(posedge clock);
		chkIrq(1'b1);
		rstn <= 1'b0;
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		rdchk(TMRC_OFS_CTRL, 0, 0);
		rdchk(TMRC_OFS_STAT, 0, 0);
		rdchk(TMRC_OFS_MASK, 0, 0);
		rdchk(TMRC_OFS_CNTL, 0, 0);
		rdchk(TMRC_OFS_CNTH, 0, 0);
		chkIrq(1'b0);
		$display("reset test done");
	endtask : t_rst
	// Reset, then scenarios
	initial
	begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		gateSignal = 1'b0;
		extEn = 1'b0;
		sleepMode = 1'b0;
		checks = 0;
		nMismatch = 0;
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		t_regs();
		t_src();
		t_ovf();
		t_rst();
		results();
	end
	// Hang guard
	initial
	begin
		#5000000;
		tmo();
	end
endmodule : tmrc_bench
`default_nettype wire
